// ==== bbth_pkg.sv ====
// Shared constants, bus carriers and state codes for the byte transfer slave.
package bbth_pkg;

   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   localparam int CM_W = 3;

   // Command codes, most significant line first.
   localparam logic [2:0] CM_IO_RD = 3'h5;
   localparam logic [2:0] CM_MEM_RD = 3'h7;
   localparam logic [2:0] CM_IO_WR = 3'h4;
   localparam logic [2:0] CM_MEM_WR = 3'h6;
   localparam logic [2:0] CM_VEC = 3'h3;

   // Local storage: a 256-byte memory page and an I/O block of seven bytes plus a status byte.
   localparam int MEM_DEPTH = 256;
   localparam int MEM_AW = 8;
   localparam int IO_AW = 3;
   localparam logic [2:0] IO_STATUS_IDX = 3'h7;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Deadman limits, selectable by a two-bit input.
   localparam int CLK_NS = 20;
   localparam int TO_SEL0_NS = 2000;
   localparam int TO_SEL1_NS = 4000;
   localparam int TO_SEL2_NS = 7000;
   localparam int TO_SEL3_NS = 16000;
   localparam int TO_W = 10;
   localparam logic [TO_W-1:0] TO_SEL0_CYC = TO_W'(TO_SEL0_NS / CLK_NS);
   localparam logic [TO_W-1:0] TO_SEL1_CYC = TO_W'(TO_SEL1_NS / CLK_NS);
   localparam logic [TO_W-1:0] TO_SEL2_CYC = TO_W'(TO_SEL2_NS / CLK_NS);
   localparam logic [TO_W-1:0] TO_SEL3_CYC = TO_W'(TO_SEL3_NS / CLK_NS);
   localparam logic [TO_W-1:0] TO_RESET = 10'h000;

   // Lines that the board samples from the backplane.
   typedef struct packed {
      logic adrstb_n;
      logic datstb_n;
      logic [CM_W-1:0] cm;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
   } bbth_bus_in_type;

   // Lines that the board drives; the acknowledge and error lines are open drain.
   typedef struct packed {
      logic [DATA_W-1:0] d;
      logic d_oe;
      logic ack_n;
      logic ack_oe;
      logic err_n;
      logic err_oe;
   } bbth_bus_out_type;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_ACK = 4'b0100,
      ST_ERR = 4'b1000
   } bbth_state_type;

endpackage

// ==== bbth_sync.sv ====
// Two flip-flop synchroniser with a constant value under reset.
`timescale 1ns/10ps
module bbth_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= INIT;
         q <= INIT;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule // bbth_sync

// ==== bbth_slave.sv ====
// Backplane byte transfer slave with system controller deadman timer.
//
// Behaviour
// - Each handshake moves one byte, fully interlocked, no shared timing.
// - Command codes: I/O read 101, memory read 111, writes 100/110, vector 011.
// - On reads the slave drives data first, then asserts acknowledge.
// - Either strobe released ends a read: drivers off, acknowledge released.
// - On writes the slave captures the byte, then asserts acknowledge.
// - Read half of read-modify-write ends on data strobe release alone.
// - Vector fetch uses only three address lines; slave drives its vector.
// - Burst repeats handshakes with address strobe, address, command stable.
// - Burst slave steps its local address on each further data strobe.
// - Slave ignores data strobe while address strobe is released.
// - Slave never asserts error and acknowledge together.
// - Data held valid until data strobe released.
// - Addressed slave may signal an illegal access with error instead of acknowledge.
// - Master releases strobes on error; slave then releases error.
// - Controller times data strobe to acknowledge and flags overrun as error.
// - After time-out master releases data strobe; controller then releases error.
// - While system reset is asserted no board takes part in transfers.
`timescale 1ns/10ps
module bbth_slave
   import bbth_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire bbth_bus_in_type bus_i,
   input wire logic dataack_n_i,
   input wire logic tfrerr_n_i,
   input wire logic sysrst_n,
   input wire logic [ADDR_W-1:MEM_AW] mem_base,
   input wire logic [ADDR_W-1:IO_AW] io_base,
   input wire logic [2:0] atn_sel,
   input wire logic atn_pending,
   input wire logic [DATA_W-1:0] vec_byte,
   input wire logic burst_down,
   input wire logic sysctl_en,
   input wire logic [1:0] to_sel,
   output bbth_bus_out_type bus_o,
   output logic atn_ack
);

   logic rst_n;
   logic [4:0] line_s;
   logic adr_act, dat_act, ack_line, err_line, bus_rst;
   logic adr_prev_q, dat_prev_q, dat_rise;
   bbth_state_type state_q;
   logic seq_first_q;
   logic [CM_W-1:0] last_cm_q;
   logic [MEM_AW-1:0] ptr_q, cur_addr;
   logic [DATA_W-1:0] mem_q [0:MEM_DEPTH-1];
   logic [DATA_W-1:0] io_q [0:6];
   logic [DATA_W-1:0] xfer_cnt_q, rd_byte, d_q;
   logic d_oe_q;
   logic mem_hit, io_hit, vec_hit, hit, is_read, is_write, illegal, start;
   logic [TO_W-1:0] to_cnt_q, to_limit;
   logic to_run_q, to_err_q, to_stop;

   bbth_sync #(.W(1), .INIT(1'b0)) u_rst_sync (
      .clk(clk),
      .nrst(nrst),
      .d(1'b1),
      .q(rst_n)
   );

   bbth_sync #(.W(5), .INIT(5'h1F)) u_line_sync (
      .clk(clk),
      .nrst(rst_n),
      .d({bus_i.adrstb_n, bus_i.datstb_n, dataack_n_i, tfrerr_n_i, sysrst_n}),
      .q(line_s)
   );

   assign adr_act = ~line_s[4];
   assign dat_act = ~line_s[3];
   assign ack_line = ~line_s[2];
   assign err_line = ~line_s[1];
   assign bus_rst = ~line_s[0];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         adr_prev_q <= 1'b0;
         dat_prev_q <= 1'b0;
      end else begin
         adr_prev_q <= adr_act;
         dat_prev_q <= dat_act;
      end
   end

   // A data strobe counts only while the address strobe is held.
   assign dat_rise = dat_act & ~dat_prev_q & adr_act & ~bus_rst;

   // Later handshakes of one sequence with an unchanged command step the pointer.
   always_comb begin
      if (seq_first_q) begin
         cur_addr = bus_i.a[MEM_AW-1:0];
      end else if (bus_i.cm == last_cm_q) begin
         cur_addr = burst_down ? ptr_q - 8'h01 : ptr_q + 8'h01;
      end else begin
         cur_addr = ptr_q;
      end
   end

   assign mem_hit = (bus_i.cm == CM_MEM_RD || bus_i.cm == CM_MEM_WR)
                    && bus_i.a[ADDR_W-1:MEM_AW] == mem_base;
   assign io_hit = (bus_i.cm == CM_IO_RD || bus_i.cm == CM_IO_WR)
                   && bus_i.a[ADDR_W-1:IO_AW] == io_base;
   assign vec_hit = bus_i.cm == CM_VEC && bus_i.a[2:0] == atn_sel && atn_pending;
   assign hit = mem_hit | io_hit | vec_hit;
   assign is_read = bus_i.cm[0];
   assign is_write = ~bus_i.cm[0] & bus_i.cm[2];
   assign illegal = io_hit & is_write & cur_addr[2:0] == IO_STATUS_IDX;
   assign start = state_q == ST_IDLE && dat_rise && hit;

   always_comb begin
      if (vec_hit) begin
         rd_byte = vec_byte;
      end else if (mem_hit) begin
         rd_byte = mem_q[cur_addr];
      end else if (cur_addr[2:0] == IO_STATUS_IDX) begin
         rd_byte = xfer_cnt_q;
      end else begin
         rd_byte = io_q[cur_addr[2:0]];
      end
   end

   // Handshake sequencer: one byte per strobe and acknowledge pair.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else if (bus_rst) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start && illegal) begin
                  state_q <= ST_ERR;
               end else if (start && is_read) begin
                  state_q <= ST_SETUP;
               end else if (start) begin
                  state_q <= ST_ACK;
               end
            end
            ST_SETUP: begin
               state_q <= (dat_act && adr_act) ? ST_ACK : ST_IDLE;
            end
            ST_ACK, ST_ERR: begin
               if (!dat_act || !adr_act) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_first_q <= 1'b1;
         last_cm_q <= CM_VEC;
         ptr_q <= BYTE_RESET;
      end else if (!adr_act) begin
         seq_first_q <= 1'b1;
      end else if (start) begin
         seq_first_q <= 1'b0;
         last_cm_q <= bus_i.cm;
         ptr_q <= cur_addr;
      end
   end

   // Read data is driven before acknowledge and held until a strobe drops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         d_q <= BYTE_RESET;
         d_oe_q <= 1'b0;
      end else if (bus_rst || !dat_act || !adr_act) begin
         d_oe_q <= 1'b0;
      end else if (start && is_read && !illegal) begin
         d_q <= rd_byte;
         d_oe_q <= 1'b1;
      end
   end

   // Storage has no reset; contents are undefined until written.
   always_ff @(posedge clk) begin
      if (start && is_write && !illegal && mem_hit) begin
         mem_q[cur_addr] <= bus_i.d;
      end
   end

   always_ff @(posedge clk) begin
      if (start && is_write && !illegal && io_hit) begin
         io_q[cur_addr[2:0]] <= bus_i.d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xfer_cnt_q <= BYTE_RESET;
         atn_ack <= 1'b0;
      end else begin
         atn_ack <= start && vec_hit;
         if (start && !illegal) begin
            xfer_cnt_q <= xfer_cnt_q + 8'h01;
         end
      end
   end

   // Deadman timer of the system controller.
   always_comb begin
      unique case (to_sel)
         2'h0: to_limit = TO_SEL0_CYC;
         2'h1: to_limit = TO_SEL1_CYC;
         2'h2: to_limit = TO_SEL2_CYC;
         2'h3: to_limit = TO_SEL3_CYC;
      endcase
   end

   assign to_stop = ack_line | err_line | ~dat_act | state_q == ST_ACK;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         to_run_q <= 1'b0;
         to_cnt_q <= TO_RESET;
      end else if (sysctl_en && dat_rise) begin
         to_run_q <= 1'b1;
         to_cnt_q <= TO_RESET;
      end else if (to_stop || to_cnt_q == to_limit - 10'h001) begin
         to_run_q <= 1'b0;
      end else if (to_run_q) begin
         to_cnt_q <= to_cnt_q + 10'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         to_err_q <= 1'b0;
      end else if (!dat_act) begin
         to_err_q <= 1'b0;
      end else if (to_run_q && !to_stop && to_cnt_q == to_limit - 10'h001) begin
         to_err_q <= 1'b1;
      end
   end

   always_comb begin
      bus_o.d = d_q;
      bus_o.d_oe = d_oe_q;
      bus_o.ack_n = 1'b0;
      bus_o.ack_oe = state_q == ST_ACK;
      bus_o.err_n = 1'b0;
      bus_o.err_oe = state_q == ST_ERR || to_err_q;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_read_start;
      start && is_read && !illegal;
   endsequence

   sequence s_write_start;
      start && is_write && !illegal && mem_hit;
   endsequence

   a_ack_err_excl: assert property (!(bus_o.ack_oe && bus_o.err_oe))
      else $error("acknowledge and error driven together");
   a_read_data_first: assert property (s_read_start |=> d_oe_q && !bus_o.ack_oe ##1 bus_o.ack_oe)
      else $error("read acknowledge not preceded by data");
   a_read_release: assert property (bus_o.ack_oe && !dat_act |=> !bus_o.ack_oe && !d_oe_q)
      else $error("acknowledge or data not released after strobe");
   a_write_capture: assert property (s_write_start |=> mem_q[ptr_q] == $past(bus_i.d) && bus_o.ack_oe)
      else $error("written byte not captured before acknowledge");
   a_ignore_datstb: assert property (state_q == ST_IDLE && !adr_act |=> state_q == ST_IDLE)
      else $error("data strobe answered without address strobe");
   a_vector_drive: assert property (start && vec_hit |=> d_q == $past(vec_byte) && atn_ack)
      else $error("vector byte not driven");
   a_burst_step: assert property (start && !seq_first_q && bus_i.cm == last_cm_q && !burst_down
      |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("burst pointer did not step");
   a_timeout_fire: assert property (to_run_q && !to_stop && to_cnt_q == to_limit - 10'h001 && dat_act
      |=> bus_o.err_oe)
      else $error("deadman overrun not flagged");
   a_timeout_clear: assert property (to_err_q && !dat_act |=> !to_err_q)
      else $error("time-out error held after strobe release");
   a_err_release: assert property (state_q == ST_ERR && !adr_act |=> state_q == ST_IDLE)
      else $error("transfer error not released");
   a_sysrst_quiet: assert property (bus_rst |=> state_q == ST_IDLE ##1 !d_oe_q)
      else $error("bus activity during system reset");

endmodule // bbth_slave

// ==== bbth_master.sv ====
// Backplane master model with the wired bus lines, facing the byte transfer slave.
`timescale 1ns/10ps
module bbth_master
   import bbth_pkg::*;
(
   input wire logic clk,
   input wire bbth_bus_out_type bus_o,
   output bbth_bus_in_type bus_i,
   output logic dataack_n_i,
   output logic tfrerr_n_i
);
   logic as_n = 1'b1;
   logic ds_n = 1'b1;
   logic m_drv = 1'b0;
   logic [CM_W-1:0] cm_r = 3'h0;
   logic [ADDR_W-1:0] a_r = 20'h00000;
   logic [DATA_W-1:0] md = 8'h00;
   logic [DATA_W-1:0] line_d;
   logic [DATA_W-1:0] last_q = 8'h00;
   logic [DATA_W-1:0] rd_s;
   logic ack_s;
   logic err_s;
   // A released data bus alternates each cycle between the inverse of the last driven byte and that byte.
   assign line_d = m_drv ? md : (bus_o.d_oe ? bus_o.d : ~last_q);
   assign dataack_n_i = bus_o.ack_oe ? bus_o.ack_n : 1'b1;
   assign tfrerr_n_i = bus_o.err_oe ? bus_o.err_n : 1'b1;
   assign bus_i = {as_n, ds_n, cm_r, a_r, line_d};
   always @(posedge clk) begin
      last_q <= line_d;
      rd_s <= line_d;
      ack_s <= dataack_n_i;
      err_s <= tfrerr_n_i;
   end
   task automatic wait_idle();
      int n;
      n = 0;
      while ((ack_s !== 1'b1 || err_s !== 1'b1) && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic open_seq(input logic [ADDR_W-1:0] addr);
      wait_idle();
      @(posedge clk);
      #1;
      a_r = addr;
      @(posedge clk);
      #1;
      as_n = 1'b0;
   endtask
   task automatic hs(input logic [CM_W-1:0] cmd, input logic [DATA_W-1:0] wd, input bit last,
      output logic [DATA_W-1:0] rd, output int resp, output int cyc);
      @(posedge clk);
      #1;
      cm_r = cmd;
      md = wd;
      m_drv = ~cmd[0];
      @(posedge clk);
      #1;
      ds_n = 1'b0;
      resp = 2;
      cyc = 0;
      while (resp == 2 && cyc < 1000) begin
         @(posedge clk);
         #1;
         cyc++;
         if (ack_s === 1'b0) resp = 0;
         else if (err_s === 1'b0) resp = 1;
      end
      rd = rd_s;
      ds_n = 1'b1;
      m_drv = 1'b0;
      if (last || resp != 0) as_n = 1'b1;
      wait_idle();
   endtask
endmodule // bbth_master

// ==== bbth_slave_tb.sv ====
// Self-checking testbench for the backplane byte transfer slave.
`timescale 1ns/10ps
module bbth_slave_tb
   import bbth_pkg::*;
   ;
   localparam logic [ADDR_W-1:0] MEMA = 20'hA5C00;
   localparam logic [ADDR_W-1:0] IOA = 20'h091A0;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sysrst_n = 1'b1;
   logic [2:0] atn_sel = 3'h5;
   logic atn_pending = 1'b0;
   logic [DATA_W-1:0] vec_byte = 8'hC7;
   logic burst_down = 1'b0;
   logic sysctl_en = 1'b1;
   logic [1:0] to_sel = 2'h0;
   logic atn_ack;
   bbth_bus_in_type bus_i;
   bbth_bus_out_type bus_o;
   logic dataack_n_i;
   logic tfrerr_n_i;
   logic [DATA_W-1:0] rd;
   logic [DATA_W-1:0] c1;
   int resp;
   int cyc;
   int atn_cnt = 0;
   int miscompares = 0;
   int tests_run = 0;
   int lim [4] = '{TO_SEL0_CYC, TO_SEL1_CYC, TO_SEL2_CYC, TO_SEL3_CYC};
   always #10 clk = ~clk;
   always @(posedge clk) if (atn_ack === 1'b1) atn_cnt <= atn_cnt + 1;
   bbth_slave DUT (.clk(clk), .nrst(nrst), .bus_i(bus_i), .dataack_n_i(dataack_n_i),
      .tfrerr_n_i(tfrerr_n_i), .sysrst_n(sysrst_n), .mem_base(MEMA[19:8]), .io_base(IOA[19:3]),
      .atn_sel(atn_sel), .atn_pending(atn_pending), .vec_byte(vec_byte),
      .burst_down(burst_down), .sysctl_en(sysctl_en), .to_sel(to_sel), .bus_o(bus_o),
      .atn_ack(atn_ack));
   bbth_master m (.clk(clk), .bus_o(bus_o), .bus_i(bus_i), .dataack_n_i(dataack_n_i),
      .tfrerr_n_i(tfrerr_n_i));
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic one(input logic [ADDR_W-1:0] ad, input logic [CM_W-1:0] c,
      input logic [DATA_W-1:0] wd);
      m.open_seq(ad);
      m.hs(c, wd, 1'b1, rd, resp, cyc);
   endtask
   task automatic t_mem_io();
      one(MEMA + 20'h5, CM_MEM_WR, 8'h3C);
      check("mem write resp", resp, 0);
      one(MEMA + 20'h5, CM_MEM_RD, 8'h00);
      check("mem read data", rd, 8'h3C);
      for (int k = 0; k < 7; k++) one(IOA + 20'(k), CM_IO_WR, 8'(8'h50 + k));
      for (int k = 0; k < 7; k++) begin
         one(IOA + 20'(k), CM_IO_RD, 8'h00);
         check("io read data", rd, 8'(8'h50 + k));
      end
      one(IOA + 20'h7, CM_IO_WR, 8'h99);
      check("illegal write resp", resp, 1);
      one(IOA + 20'h7, CM_IO_RD, 8'h00);
      c1 = rd;
      one(IOA + 20'h7, CM_IO_RD, 8'h00);
      check("count step", rd, 8'(c1 + 8'h01));
      $display("test mem_io done");
   endtask
   task automatic t_burst_rmw();
      m.open_seq(MEMA + 20'h10);
      for (int k = 0; k < 3; k++) m.hs(CM_MEM_WR, 8'(8'hB0 + k), k == 2, rd, resp, cyc);
      m.open_seq(MEMA + 20'h10);
      for (int k = 0; k < 3; k++) begin
         m.hs(CM_MEM_RD, 8'h00, k == 2, rd, resp, cyc);
         check("burst up data", rd, 8'(8'hB0 + k));
      end
      burst_down = 1'b1;
      m.open_seq(MEMA + 20'h20);
      m.hs(CM_MEM_WR, 8'hD0, 1'b0, rd, resp, cyc);
      m.hs(CM_MEM_WR, 8'hD1, 1'b1, rd, resp, cyc);
      burst_down = 1'b0;
      one(MEMA + 20'h1F, CM_MEM_RD, 8'h00);
      check("burst down data", rd, 8'hD1);
      one(MEMA + 20'h40, CM_MEM_WR, 8'h81);
      m.open_seq(MEMA + 20'h40);
      m.hs(CM_MEM_RD, 8'h00, 1'b0, rd, resp, cyc);
      check("rmw read data", rd, 8'h81);
      m.hs(CM_MEM_WR, 8'h7E, 1'b1, rd, resp, cyc);
      check("rmw write resp", resp, 0);
      one(MEMA + 20'h40, CM_MEM_RD, 8'h00);
      check("rmw result", rd, 8'h7E);
      $display("test burst_rmw done");
   endtask
   task automatic t_vec_stray();
      logic seen;
      atn_pending = 1'b1;
      one(20'hFFFF5, CM_VEC, 8'h00);
      check("vector data", rd, 8'hC7);
      check("attention ack pulses", atn_cnt, 1);
      atn_pending = 1'b0;
      seen = 1'b0;
      @(posedge clk);
      #1;
      m.ds_n = 1'b0;
      repeat (10) begin
         @(negedge clk);
         seen = seen | bus_o.ack_oe | bus_o.d_oe | bus_o.err_oe;
      end
      @(posedge clk);
      #1;
      m.ds_n = 1'b1;
      check("stray strobe answer", seen, 0);
      $display("test vec_stray done");
   endtask
   task automatic t_dead_reset();
      for (int s = 0; s < 4; s++) begin
         to_sel = 2'(s);
         one(20'h00000, CM_MEM_RD, 8'h00);
         check("timeout resp", resp, 1);
         check("timeout span", cyc >= lim[s] && cyc <= lim[s] + 8, 1);
      end
      sysctl_en = 1'b0;
      sysrst_n = 1'b0;
      repeat (4) @(posedge clk);
      one(MEMA + 20'h5, CM_MEM_RD, 8'h00);
      check("reset held resp", resp, 2);
      sysrst_n = 1'b1;
      sysctl_en = 1'b1;
      one(MEMA + 20'h5, CM_MEM_RD, 8'h00);
      check("after reset data", rd, 8'h3C);
      $display("test dead_reset done");
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #1;
      nrst = 1'b1;
      t_mem_io();
      t_burst_rmw();
      t_vec_stray();
      t_dead_reset();
      stop_test();
   end
   initial begin
      #400000;
      miscompares++;
      stop_test();
   end
endmodule // bbth_slave_tb
